//--- inc/rscc_consts.vh
// constants for the radio state control configuration block
//
// Contract
// RQ1: after a packet go idle on next-state 0, stay in receive on 3
// RQ2: autocal policy 0 never calibrates; only the calibrate strobe does
// RQ3: policy 1 calibrates idle-to-receive, 2 on automatic return to idle
// RQ4: policy 3 calibrates on every fourth automatic return to idle
// RQ5: chip-ready-low high until ripple counter expired the selected count
// RQ6: delay select 0,1,2,3 gives 1,16,64,256 ripple-counter expirations
// RQ7: host should select 2 when oscillator stays on during power-down
// RQ8: host should select 2 or 3 when oscillator stops during power-down
// RQ9: keep-oscillator bit 0 keeps crystal oscillator running in sleep; code keeps it running in sleep only when the bit is 1
// RQ10: oscillator-settled flag asserts in the same cycle as chip-ready
// RQ11: reserved next-state values behave as the idle setting
`ifndef RSCC_CONSTS_VH
`define RSCC_CONSTS_VH
`define RSCC_ADDR_W        6
`define RSCC_ADDR_CFG_ONE  6'h17
`define RSCC_ADDR_CFG_ZERO 6'h18
`define RSCC_RST_CFG_ONE   8'h30
`define RSCC_RST_CFG_ZERO  8'h04
`define RSCC_ONE_WMASK     8'h3f
`define RSCC_ZERO_WMASK    8'h3f
`define RSCC_NXT_HI        3
`define RSCC_NXT_LO        2
`define RSCC_CAL_HI        5
`define RSCC_CAL_LO        4
`define RSCC_POD_HI        3
`define RSCC_POD_LO        2
`define RSCC_KEEP_BIT      0
`define RSCC_NXT_STAY_RX   2'h3
`define RSCC_CAL_NEVER     2'h0
`define RSCC_CAL_TO_RX     2'h1
`define RSCC_CAL_TO_IDLE   2'h2
`define RSCC_CAL_EVERY4    2'h3
`define RSCC_CAL_DIV_LAST  2'h3
`define RSCC_EXP_0         9'h001
`define RSCC_EXP_1         9'h010
`define RSCC_EXP_2         9'h040
`define RSCC_EXP_3         9'h100
`define RSCC_RIPPLE_W      6
`define RSCC_RIPPLE_LAST   6'h3f
`endif

//--- design/rscc_por_delay.v
// power-on delay: counts six-bit ripple expirations after oscillator settles
`timescale 1ns/1ps
`include "rscc_consts.vh"
module rscc_por_delay (
   clk_sys,
   rst_n,
   osc_settled_raw,
   delay_select,
   ready
);
   input  wire       clk_sys;
   input  wire       rst_n;
   input  wire       osc_settled_raw;
   input  wire [1:0] delay_select;
   output reg        ready;

   reg [`RSCC_RIPPLE_W-1:0] ripple_ff;
   reg [8:0]                expire_ff;
   wire [8:0]               target;

   // expiration count per select code
   function [8:0] expire_count;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: expire_count = `RSCC_EXP_0;
            2'h1: expire_count = `RSCC_EXP_1;
            2'h2: expire_count = `RSCC_EXP_2;
            default: expire_count = `RSCC_EXP_3;
         endcase
      end
   endfunction

   assign target = expire_count(delay_select); // RQ6

   // count expirations; oscillator drop restarts the delay
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ripple_ff <= {`RSCC_RIPPLE_W{1'b0}};
         expire_ff <= 9'h000;
         ready     <= 1'b0;
      end else if (!osc_settled_raw) begin
         ripple_ff <= {`RSCC_RIPPLE_W{1'b0}};
         expire_ff <= 9'h000;
         ready     <= 1'b0;
      end else if (!ready) begin
         ripple_ff <= ripple_ff + 1'b1;
         if (ripple_ff == `RSCC_RIPPLE_LAST) begin
            expire_ff <= expire_ff + 9'h001;
            if (expire_ff + 9'h001 >= target) begin
               ready <= 1'b1; // RQ5
            end
         end
      end
   end
endmodule // rscc_por_delay

//--- design/rscc_top.v
// radio state control configuration registers and their effects
`timescale 1ns/1ps
`include "rscc_consts.vh"
module rscc_top (
   clk_sys,
   rstn,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata,
   osc_running_in,
   packet_done,
   rx_exit_auto,
   idle_to_rx,
   in_sleep,
   calibrate_strobe_command,
   post_rx_stay_rx,
   synth_cal_start,
   osc_enable,
   oscillator_settled_flag,
   chip_ready_low
);
   input  wire                     clk_sys;
   input  wire                     rstn;
   input  wire                     reg_wr;
   input  wire                     reg_rd;
   input  wire [`RSCC_ADDR_W-1:0]  reg_addr;
   input  wire [7:0]               reg_wdata;
   output reg  [7:0]               reg_rdata;
   input  wire                     osc_running_in;
   input  wire                     packet_done;
   input  wire                     rx_exit_auto;
   input  wire                     idle_to_rx;
   input  wire                     in_sleep;
   input  wire                     calibrate_strobe_command;
   output reg                      post_rx_stay_rx;
   output reg                      synth_cal_start;
   output reg                      osc_enable;
   output reg                      oscillator_settled_flag;
   output reg                      chip_ready_low;

   reg        rst_s1_ff;
   reg        rst_s2_ff;
   reg        osc_s1_ff;
   reg        osc_s2_ff;
   reg [7:0]  cfg_one_ff;
   reg [7:0]  cfg_zero_ff;
   reg [1:0]  idle_cnt_ff;
   reg [1:0]  nxt_idle_cnt;
   reg        cal_now;
   wire [1:0] post_rx_sel;
   wire [1:0] cal_policy;
   wire [1:0] po_delay_sel;
   wire       keep_osc;
   wire       por_ready;

   // reset release through two flops
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   // oscillator status pin synchroniser
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
      end else begin
         osc_s1_ff <= osc_running_in;
         osc_s2_ff <= osc_s1_ff;
      end
   end

   // field views of the two configuration registers
   assign post_rx_sel  = cfg_one_ff[`RSCC_NXT_HI:`RSCC_NXT_LO];
   assign cal_policy   = cfg_zero_ff[`RSCC_CAL_HI:`RSCC_CAL_LO];
   assign po_delay_sel = cfg_zero_ff[`RSCC_POD_HI:`RSCC_POD_LO];
   assign keep_osc     = cfg_zero_ff[`RSCC_KEEP_BIT];

   // address decode shared by the write and read paths
   function hit_cfg_one;
      input [`RSCC_ADDR_W-1:0] addr;
      begin
         hit_cfg_one = (addr == `RSCC_ADDR_CFG_ONE);
      end
   endfunction

   function hit_cfg_zero;
      input [`RSCC_ADDR_W-1:0] addr;
      begin
         hit_cfg_zero = (addr == `RSCC_ADDR_CFG_ZERO);
      end
   endfunction

   // register writes; reserved top bits stay zero
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         cfg_one_ff  <= `RSCC_RST_CFG_ONE;
         cfg_zero_ff <= `RSCC_RST_CFG_ZERO;
      end else if (reg_wr) begin
         if (hit_cfg_one(reg_addr)) begin
            cfg_one_ff <= reg_wdata & `RSCC_ONE_WMASK;
         end
         if (hit_cfg_zero(reg_addr)) begin
            cfg_zero_ff <= reg_wdata & `RSCC_ZERO_WMASK;
         end
      end
   end

   // register read; data holds between reads so the host may sample late
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (hit_cfg_one(reg_addr)) begin
            reg_rdata <= cfg_one_ff;
         end else if (hit_cfg_zero(reg_addr)) begin
            reg_rdata <= cfg_zero_ff;
         end else begin
            reg_rdata <= 8'h00; // unmapped addresses read zero
         end
      end
   end

   // every-fourth counter advances only while that policy is selected
   always @* begin
      nxt_idle_cnt = idle_cnt_ff;
      if (rx_exit_auto && cal_policy == `RSCC_CAL_EVERY4) begin
         nxt_idle_cnt = idle_cnt_ff + 2'h1; // RQ4
      end
   end

   // calibration decision from policy and transitions
   always @* begin
      cal_now = 1'b0;
      case (cal_policy)
         `RSCC_CAL_NEVER:   cal_now = 1'b0; // RQ2
         `RSCC_CAL_TO_RX:   cal_now = idle_to_rx; // RQ3
         `RSCC_CAL_TO_IDLE: cal_now = rx_exit_auto; // RQ3
         `RSCC_CAL_EVERY4:  cal_now = rx_exit_auto &&
                               (idle_cnt_ff == `RSCC_CAL_DIV_LAST); // RQ4
         default:           cal_now = 1'b0;
      endcase
   end

   // automatic return counter; not cleared when the policy changes
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         idle_cnt_ff <= 2'h0;
      end else begin
         idle_cnt_ff <= nxt_idle_cnt;
      end
   end

   // calibration start pulse; the host strobe works under every policy
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         synth_cal_start <= 1'b0;
      end else begin
         synth_cal_start <= cal_now || calibrate_strobe_command; // RQ2
      end
   end

   // next-state output; only code 3 stays, reserved codes act as idle
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         post_rx_stay_rx <= 1'b0;
      end else begin
         post_rx_stay_rx <= (post_rx_sel == `RSCC_NXT_STAY_RX); // RQ1 RQ11
      end
   end

   // power-on delay counter
   rscc_por_delay u_por (
      .clk_sys         (clk_sys),
      .rst_n           (rst_s2_ff),
      .osc_settled_raw (osc_s2_ff),
      .delay_select    (po_delay_sel),
      .ready           (por_ready)
   );

   // ready pair moves on one edge so no gap opens between them
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         chip_ready_low          <= 1'b1;
         oscillator_settled_flag <= 1'b0;
      end else begin
         chip_ready_low          <= ~por_ready; // RQ5
         oscillator_settled_flag <= por_ready; // RQ10
      end
   end

   // oscillator kept running in sleep on request
   always @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         osc_enable <= 1'b1;
      end else begin
         osc_enable <= ~in_sleep | keep_osc; // RQ9
      end
   end
endmodule // rscc_top

//--- sim/rscc_checker.sv
// assertion checker for the radio state control configuration block
`timescale 1ns/1ps
`include "rscc_consts.vh"
module rscc_checker (
   input wire                    clk_sys,
   input wire                    rstn,
   input wire                    reg_wr,
   input wire [`RSCC_ADDR_W-1:0] reg_addr,
   input wire [7:0]              reg_wdata,
   input wire                    osc_running_in,
   input wire                    rx_exit_auto,
   input wire                    idle_to_rx,
   input wire                    in_sleep,
   input wire                    calibrate_strobe_command,
   input wire                    post_rx_stay_rx,
   input wire                    synth_cal_start,
   input wire                    osc_enable,
   input wire                    oscillator_settled_flag,
   input wire                    chip_ready_low
);
   reg [5:0]  one_ff, zero_ff;
   reg [1:0]  four_ff;
   reg [14:0] run_ff;
   wire [14:0] due_run;
   // cycles from pin rise to ready fall: two sync, N times 64, one register
   assign due_run = (zero_ff[3:2] == 2'h0) ? 15'h0043 :
      (zero_ff[3:2] == 2'h1) ? 15'h0403 :
      (zero_ff[3:2] == 2'h2) ? 15'h1003 : 15'h4003;
   // shadow registers, every-fourth count, cycles since oscillator start
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         one_ff  <= 6'h30;
         zero_ff <= 6'h04;
         four_ff <= 2'h0;
         run_ff  <= 15'h0000;
      end else begin
         if (reg_wr && reg_addr == 6'h17) one_ff <= reg_wdata[5:0];
         if (reg_wr && reg_addr == 6'h18) zero_ff <= reg_wdata[5:0];
         if (rx_exit_auto && zero_ff[5:4] == 2'h3) four_ff <= four_ff + 2'h1;
         run_ff <= osc_running_in ? run_ff + {14'h0000, ~&run_ff} : 15'h0000;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   AST_NXT: assert property (
      !$past(reg_wr) && !$past(reg_wr, 2) |->
      post_rx_stay_rx == (one_ff[3:2] == 2'h3)) else $error("next state");
   AST_NEVER: assert property (synth_cal_start && zero_ff[5:4] == 2'h0
      |-> $past(calibrate_strobe_command)) else $error("cal policy 0");
   AST_TO_RX: assert property (idle_to_rx && zero_ff[5:4] == 2'h1
      |=> synth_cal_start) else $error("cal policy 1");
   AST_TO_IDLE: assert property (rx_exit_auto && zero_ff[5:4] == 2'h2
      |=> synth_cal_start) else $error("cal policy 2");
   AST_EVERY4: assert property (rx_exit_auto && zero_ff[5:4] == 2'h3 &&
      !calibrate_strobe_command |=> synth_cal_start == ($past(four_ff) ==
      2'h3)) else $error("cal policy 3");
   AST_PAIR: assert property (oscillator_settled_flag != chip_ready_low)
      else $error("ready pair");
   AST_DELAY: assert property ($fell(chip_ready_low) |->
      run_ff == due_run) else $error("ready timing");
   AST_KEEP: assert property (osc_enable == (!$past(in_sleep) ||
      $past(zero_ff[0]))) else $error("osc enable");
   cover property (synth_cal_start);
   cover property ($fell(chip_ready_low));
   cover property (!osc_enable);
endmodule // rscc_checker
bind rscc_top rscc_checker u_chk (.clk_sys, .rstn, .reg_wr, .reg_addr,
   .reg_wdata, .osc_running_in, .rx_exit_auto, .idle_to_rx, .in_sleep,
   .calibrate_strobe_command, .post_rx_stay_rx, .synth_cal_start,
   .osc_enable, .oscillator_settled_flag, .chip_ready_low);

//--- sim/tb_top.sv
// self-checking testbench for the radio state control configuration block
`timescale 1ns/1ps
module tb_top;
   logic       clk_sys, rstn, reg_wr, reg_rd, in_sleep, idle_to_rx;
   logic       rx_exit_auto, calibrate_strobe_command, osc_running_in;
   logic       stay, cal, osc_en, settled, rdy_n;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] four;
   int         fails, num_checks, cyc, n, k;
   rscc_top uut (.clk_sys, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .osc_running_in, .packet_done(1'b0), .rx_exit_auto,
      .idle_to_rx, .in_sleep, .calibrate_strobe_command,
      .post_rx_stay_rx(stay), .synth_cal_start(cal), .osc_enable(osc_en),
      .oscillator_settled_flag(settled), .chip_ready_low(rdy_n));
   // clock and hang ceiling
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         complete_run();
      end
   end
   task chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'h0;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      @(negedge clk_sys);
      chk(reg_rdata, e);
   endtask
   function logic exp_cal(int kd, logic [1:0] p);
      return kd == 0 || (kd == 1 && p == 2'h1) || (kd == 2 && (p == 2'h2 ||
         (p == 2'h3 && four == 2'h3)));
   endfunction
   task pulse(input int kd, input logic [1:0] p);
      @(posedge clk_sys);
      {calibrate_strobe_command, idle_to_rx, rx_exit_auto} <= 3'h4 >> kd;
      @(posedge clk_sys);
      {calibrate_strobe_command, idle_to_rx, rx_exit_auto} <= 3'h0;
      @(negedge clk_sys);
      chk(cal, exp_cal(kd, p));
      if (kd == 2 && p == 2'h3) four++;
   endtask
   task complete_run();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // main sequence
   initial begin
      {rstn, reg_wr, reg_rd, in_sleep, idle_to_rx, rx_exit_auto} = 6'h00;
      {calibrate_strobe_command, osc_running_in, four} = 4'h0;
      {reg_addr, reg_wdata} = 14'h0000;
      {fails, num_checks, cyc} = 96'h0;
      void'($urandom(32'h040d));
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(6'h17, 8'h30);
      rd(6'h18, 8'h04);
      rd(6'h2a, 8'h00);
      acc(1'b1, 6'h17, 8'hff);
      rd(6'h17, 8'h3f);
      for (k = 0; k < 4; k++) begin
         acc(1'b1, 6'h17, 8'($urandom) & 8'hf3 | {k[1:0], 2'h0});
         repeat (3) @(negedge clk_sys);
         chk(stay, k == 3);
      end
      for (k = 0; k < 4; k++) begin
         acc(1'b1, 6'h18, {4'h0, k[1:0], 2'h0});
         osc_running_in <= 1'b1;
         n = 0;
         while (rdy_n !== 1'b0 && n < 20000) begin
            @(negedge clk_sys);
            n++;
         end
         chk(n / 64, k == 0 ? 1 : 1 << (2 * k + 2));
         chk(settled, 1'b1);
         osc_running_in <= 1'b0;
         repeat (8) @(posedge clk_sys);
      end
      for (k = 0; k < 4; k++) begin
         acc(1'b1, 6'h18, {2'h0, k[1:0], 4'h0});
         repeat (12) pulse($urandom % 3, k[1:0]);
         repeat (4) pulse(2, k[1:0]);
      end
      @(posedge clk_sys);
      in_sleep <= 1'b1;
      for (k = 0; k < 2; k++) begin
         acc(1'b1, 6'h18, {4'h0, 2'h2, 1'b0, k[0]});
         repeat (2) @(negedge clk_sys);
         chk(osc_en, k[0]);
      end
      complete_run();
   end
endmodule // tb_top
